// file: rtl/dps_top.sv
// dps_top: drive protection supervisor with an AHB-Lite register slave.
// assumes a single-master AHB-Lite bus and synchronous sensor inputs.
// Contract
// - select 0: no current-based frequency cut
// - mode 1 over level: lower frequency
// - below level: resume prior running state
// - limit level 20.0-180.0%, default 150.0
// - current limiting only in V/F mode
// - quick limit bit, default off
// - retry count 0-20, zero disables retry
// - retry interval 0.01-30.00 s, default 0.50
// - retry only selected faults, others report
// - reset and retry until count exhausted
// - fault output during retries is selectable
// - clear retry count after restore time
// - early recurrence continues previous count
// - stop bit 0 coasts, 1 stop method
// - two stop fields, second uses four bits
// - underload detect below level for time
// - underload response: coast, stop, or signal
// - regulation 0: no voltage compensation
// - mode 1 low input, freq_out above vf_freq: maximum voltage
// - mode 1 high input: scale voltage down
// - mode 2 regulates except while decelerating
`timescale 1ns/1ps
`default_nettype none
module dps_top import dps_pkg::*; #(
  parameter int TICK_CYCLES = TICK_DIV,
  parameter int NFAULT = 12
) (
  // clocking
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // drive measurements, current in 0.1% of rated
  input wire logic [10:0] out_current,
  input wire logic [15:0] in_voltage,
  input wire logic [15:0] rated_voltage,
  input wire logic [15:0] freq_cmd,
  input wire logic [15:0] vf_freq,
  input wire logic [15:0] vf_voltage,
  input wire logic [15:0] max_voltage,
  input wire logic vf_mode,
  input wire logic running,
  input wire logic decelerating,
  input wire logic dc_braking,
  input wire logic fault_reset,
  input wire logic [NFAULT-1:0] fault_in,
  // drive commands
  output logic [15:0] freq_out,
  output logic [15:0] volt_out,
  output logic cur_limiting,
  output logic quick_limit,
  output logic fault_reset_pulse,
  output logic fault_report,
  output logic fault_do,
  output logic coast_stop,
  output logic method_stop,
  output logic underload_do
);
  // configuration
  logic [1:0] current_limit_select_reg;
  logic [10:0] current_limit_level_reg;
  logic quick_limit_select_reg;
  logic [4:0] retry_count_limit_reg;
  logic retry_output_action_reg;
  logic [7:0] retry_fault_select_reg;
  logic [11:0] retry_interval_reg;
  logic [11:0] retry_restore_time_reg;
  logic [7:0] fault_stop_action_a_reg;
  logic [3:0] fault_stop_action_b_reg;
  logic underload_enable_reg;
  logic [9:0] underload_level_reg;
  logic [12:0] underload_time_reg;
  logic [1:0] underload_action_reg;
  logic [1:0] voltage_regulation_select_reg;
  // status
  dps_state_t state_reg;
  logic [4:0] retry_cnt_reg;
  logic [11:0] ivl_cnt_reg;
  logic [11:0] restore_cnt_reg;
  logic restoring_reg;
  logic [12:0] ul_cnt_reg;
  logic underload_reg;
  logic [15:0] freq_cut_reg;
  logic [NFAULT-1:0] fault_seen_reg;
  logic tick;
  // bus address phase capture
  logic wr_pend_reg;
  logic [7:0] addr_reg;

  function automatic logic [11:0] clamp12(input logic [31:0] v, input logic [11:0] lo,
                                          input logic [11:0] hi);
    if (v[31:12] != 20'h0 || v[11:0] > hi) begin
      clamp12 = hi;
    end else if (v[11:0] < lo) begin
      clamp12 = lo;
    end else begin
      clamp12 = v[11:0];
    end
  endfunction

  dps_tick #(.DIV(TICK_CYCLES)) u_tick (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .tick(tick)
  );

  wire logic take = hsel && hready && htrans[1];
  wire logic [NFAULT-1:0] stop_sel = {fault_stop_action_b_reg, fault_stop_action_a_reg};
  wire logic [NFAULT-1:0] retry_sel = {{(NFAULT-8){1'b0}}, retry_fault_select_reg};
  wire logic any_fault = |fault_in;
  wire logic fatal_fault = |(fault_in & ~retry_sel);
  wire logic limit_on = vf_mode && current_limit_select_reg == 2'h1;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h0;
    end else if (clk_en && hready) begin
      wr_pend_reg <= take && hwrite;
      addr_reg <= haddr[7:0];
    end
  end

  // register writes, values outside the range are clamped
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      current_limit_select_reg <= CL_SEL_RST;
      current_limit_level_reg <= CL_LEVEL_RST;
      quick_limit_select_reg <= 1'b0;
      retry_count_limit_reg <= 5'h0;
      retry_output_action_reg <= 1'b0;
      retry_fault_select_reg <= 8'h0;
      retry_interval_reg <= RETRY_IVL_RST;
      retry_restore_time_reg <= RETRY_RST_RST;
      fault_stop_action_a_reg <= 8'h0;
      fault_stop_action_b_reg <= 4'h0;
      underload_enable_reg <= 1'b0;
      underload_level_reg <= UL_LEVEL_RST;
      underload_time_reg <= UL_TIME_RST;
      underload_action_reg <= UL_ACT_RST;
      voltage_regulation_select_reg <= VREG_RST;
    end else if (clk_en && wr_pend_reg) begin
      case (addr_reg)
        OFS_CURLIM: begin
          current_limit_select_reg <= hwdata[1:0] > 2'h2 ? 2'h2 : hwdata[1:0];
          current_limit_level_reg <= 11'(clamp12({16'h0, hwdata[31:16]},
                                                 12'(CL_LEVEL_MIN), 12'(CL_LEVEL_MAX)));
          quick_limit_select_reg <= hwdata[4];
        end
        OFS_RETRY: begin
          retry_count_limit_reg <= hwdata[4:0] > RETRY_MAX ? RETRY_MAX : hwdata[4:0];
          retry_output_action_reg <= hwdata[8];
          retry_fault_select_reg <= hwdata[23:16];
        end
        OFS_RETRY_IVL: retry_interval_reg <= clamp12(hwdata, 12'h1, RETRY_IVL_MAX);
        OFS_RETRY_RST: retry_restore_time_reg <= clamp12(hwdata, 12'h1, RETRY_IVL_MAX);
        OFS_STOP_A: fault_stop_action_a_reg <= hwdata[7:0];
        OFS_STOP_B: fault_stop_action_b_reg <= hwdata[3:0];
        OFS_UNDERLOAD: begin
          underload_enable_reg <= hwdata[0];
          underload_action_reg <= hwdata[5:4] > 2'h2 ? 2'h2 : hwdata[5:4];
          underload_level_reg <= 10'(clamp12({22'h0, hwdata[25:16]}, 12'h0, 12'h3e8));
        end
        OFS_UL_TIME: underload_time_reg <= |hwdata[31:13] || hwdata[12:0] > UL_TIME_MAX ?
                                           UL_TIME_MAX : hwdata[12:0];
        OFS_VREG: voltage_regulation_select_reg <= hwdata[1:0] > 2'h2 ? 2'h2 : hwdata[1:0];
        default: ;
      endcase
    end
  end

  // read data launched at the address phase; a read right behind a write sees the old value
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      hrdata <= 32'h0;
    end else if (clk_en && take && !hwrite) begin
      case (haddr[7:0])
        OFS_CURLIM: hrdata <= {5'h0, current_limit_level_reg, 11'h0, quick_limit_select_reg,
                               2'h0, current_limit_select_reg};
        OFS_RETRY: hrdata <= {8'h0, retry_fault_select_reg, 7'h0, retry_output_action_reg,
                              3'h0, retry_count_limit_reg};
        OFS_RETRY_IVL: hrdata <= {20'h0, retry_interval_reg};
        OFS_RETRY_RST: hrdata <= {20'h0, retry_restore_time_reg};
        OFS_STOP_A: hrdata <= {24'h0, fault_stop_action_a_reg};
        OFS_STOP_B: hrdata <= {28'h0, fault_stop_action_b_reg};
        OFS_UNDERLOAD: hrdata <= {6'h0, underload_level_reg, 10'h0, underload_action_reg,
                                  3'h0, underload_enable_reg};
        OFS_UL_TIME: hrdata <= {19'h0, underload_time_reg};
        OFS_VREG: hrdata <= {30'h0, voltage_regulation_select_reg};
        OFS_STATUS: hrdata <= {3'h0, retry_cnt_reg, underload_reg, cur_limiting,
                               state_reg, 4'h0, 16'(fault_seen_reg)};
        default: hrdata <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // current limiting: step frequency down while over level, release below
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      freq_cut_reg <= 16'h0;
      cur_limiting <= 1'b0;
      freq_out <= 16'h0;
      quick_limit <= 1'b0;
    end else if (clk_en) begin
      quick_limit <= quick_limit_select_reg && vf_mode;
      if (!limit_on || !running) begin
        freq_cut_reg <= 16'h0;
        cur_limiting <= 1'b0;
      end else if (out_current >= current_limit_level_reg) begin
        cur_limiting <= 1'b1;
        if (freq_cut_reg < freq_cmd) begin
          freq_cut_reg <= freq_cut_reg + VF_STEP;
        end
      end else begin
        cur_limiting <= 1'b0;
        freq_cut_reg <= 16'h0;
      end
      freq_out <= freq_cmd - (freq_cut_reg > freq_cmd ? freq_cmd : freq_cut_reg);
    end
  end

  // output voltage regulation
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      volt_out <= 16'h0;
    end else if (clk_en) begin
      case (voltage_regulation_select_reg)
        VREG_OFF: volt_out <= vf_voltage;
        VREG_ON: begin
          if (in_voltage < rated_voltage && freq_out > vf_freq) begin
            volt_out <= max_voltage;
          end else if (in_voltage > rated_voltage && in_voltage != 16'h0) begin
            volt_out <= 16'((32'(vf_voltage) * 32'(rated_voltage)) / 32'(in_voltage));
          end else begin
            volt_out <= vf_voltage;
          end
        end
        VREG_AUTO: begin
          if (!decelerating && in_voltage != 16'h0) begin
            volt_out <= 16'((32'(vf_voltage) * 32'(rated_voltage)) / 32'(in_voltage));
          end else begin
            volt_out <= vf_voltage;
          end
        end
        default: volt_out <= vf_voltage;
      endcase
    end
  end

  // underload detection in 10 ms steps
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ul_cnt_reg <= 13'h0;
      underload_reg <= 1'b0;
    end else if (clk_en) begin
      if (!underload_enable_reg || !running || dc_braking ||
          out_current >= 11'(underload_level_reg)) begin
        ul_cnt_reg <= 13'h0;
        underload_reg <= 1'b0;
      end else if (ul_cnt_reg >= underload_time_reg) begin
        underload_reg <= 1'b1;
      end else if (tick) begin
        ul_cnt_reg <= ul_cnt_reg + 13'h1;
      end
    end
  end

  // retry sequencer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= DPS_RUN;
      retry_cnt_reg <= 5'h0;
      ivl_cnt_reg <= 12'h0;
      restore_cnt_reg <= 12'h0;
      restoring_reg <= 1'b0;
      fault_seen_reg <= '0;
      fault_reset_pulse <= 1'b0;
      fault_report <= 1'b0;
      fault_do <= 1'b0;
    end else if (clk_en) begin
      fault_reset_pulse <= 1'b0;
      fault_seen_reg <= fault_seen_reg | fault_in;
      case (state_reg)
        DPS_RUN: begin
          if (fatal_fault || (any_fault && retry_cnt_reg >= retry_count_limit_reg) ||
              (underload_reg && underload_action_reg != UL_ACT_RUN)) begin
            state_reg <= DPS_LATCH;
            fault_report <= 1'b1;
            // stop kind must follow what caused the latch, not older retried faults
            fault_seen_reg <= fault_in;
            fault_do <= 1'b1;
          end else if (any_fault) begin
            state_reg <= DPS_WAIT;
            retry_cnt_reg <= retry_cnt_reg + 5'h1;
            fault_reset_pulse <= 1'b1;
            fault_do <= retry_output_action_reg;
            ivl_cnt_reg <= 12'h0;
            restoring_reg <= 1'b0;
          end else if (restoring_reg) begin
            if (restore_cnt_reg >= retry_restore_time_reg) begin
              retry_cnt_reg <= 5'h0;
              restoring_reg <= 1'b0;
            end else if (tick) begin
              restore_cnt_reg <= restore_cnt_reg + 12'h1;
            end
          end
        end
        DPS_WAIT: begin
          if (fatal_fault) begin
            state_reg <= DPS_LATCH;
            fault_report <= 1'b1;
            fault_seen_reg <= fault_in;
            fault_do <= 1'b1;
          end else if (ivl_cnt_reg >= retry_interval_reg) begin
            state_reg <= DPS_RUN;
            ivl_cnt_reg <= 12'h0;
            restore_cnt_reg <= 12'h0;
            restoring_reg <= 1'b1;
            fault_do <= 1'b0;
          end else if (tick) begin
            ivl_cnt_reg <= ivl_cnt_reg + 12'h1;
          end
        end
        DPS_LATCH: begin
          if (fault_reset) begin
            state_reg <= DPS_RUN;
            fault_report <= 1'b0;
            fault_do <= 1'b0;
            retry_cnt_reg <= 5'h0;
            fault_seen_reg <= fault_in;
          end
        end
        default: state_reg <= DPS_RUN;
      endcase
    end
  end

  // stop kind: per-fault bit, underload response picks its own
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      coast_stop <= 1'b0;
      method_stop <= 1'b0;
      underload_do <= 1'b0;
    end else if (clk_en) begin
      underload_do <= underload_reg && underload_action_reg == UL_ACT_RUN;
      if (state_reg == DPS_LATCH) begin
        if (|fault_seen_reg) begin
          method_stop <= |(fault_seen_reg & stop_sel);
          coast_stop <= |(fault_seen_reg & ~stop_sel);
        end else begin
          method_stop <= underload_action_reg == UL_ACT_STOP;
          coast_stop <= underload_action_reg == UL_ACT_COAST;
        end
      end else begin
        coast_stop <= state_reg == DPS_WAIT;
        method_stop <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/dps_pkg.sv
// dps_pkg: register map, field limits, reset values and timing counts
// for the drive protection supervisor; assumes a 40 MHz system clock.
package dps_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int TICK_HZ = 100;
  localparam int TICK_DIV = CLK_HZ / TICK_HZ;
  localparam logic [7:0] OFS_CURLIM = 8'h00;
  localparam logic [7:0] OFS_RETRY = 8'h04;
  localparam logic [7:0] OFS_RETRY_IVL = 8'h08;
  localparam logic [7:0] OFS_RETRY_RST = 8'h0c;
  localparam logic [7:0] OFS_STOP_A = 8'h10;
  localparam logic [7:0] OFS_STOP_B = 8'h14;
  localparam logic [7:0] OFS_UNDERLOAD = 8'h18;
  localparam logic [7:0] OFS_UL_TIME = 8'h1c;
  localparam logic [7:0] OFS_VREG = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_CTRL = 8'h28;
  localparam logic [1:0] CL_SEL_RST = 2'h2;
  localparam logic [10:0] CL_LEVEL_RST = 11'h5dc;
  localparam logic [10:0] CL_LEVEL_MIN = 11'h0c8;
  localparam logic [10:0] CL_LEVEL_MAX = 11'h708;
  localparam logic [4:0] RETRY_MAX = 5'h14;
  localparam logic [11:0] RETRY_IVL_RST = 12'h032;
  localparam logic [11:0] RETRY_IVL_MAX = 12'hbb8;
  localparam logic [11:0] RETRY_RST_RST = 12'h3e8;
  localparam logic [9:0] UL_LEVEL_RST = 10'h014;
  localparam logic [12:0] UL_TIME_RST = 13'h0064;
  localparam logic [12:0] UL_TIME_MAX = 13'h1770;
  localparam logic [1:0] UL_ACT_RST = 2'h1;
  localparam logic [1:0] VREG_RST = 2'h1;
  localparam logic [1:0] UL_ACT_COAST = 2'h0;
  localparam logic [1:0] UL_ACT_STOP = 2'h1;
  localparam logic [1:0] UL_ACT_RUN = 2'h2;
  localparam logic [1:0] VREG_OFF = 2'h0;
  localparam logic [1:0] VREG_ON = 2'h1;
  localparam logic [1:0] VREG_AUTO = 2'h2;
  localparam logic [15:0] VF_STEP = 16'h0001;
  typedef enum logic [1:0] {DPS_RUN, DPS_WAIT, DPS_LATCH} dps_state_t;
endpackage

// file: rtl/dps_tick.sv
// dps_tick: 10 ms time base for the supervisor's second-scale timers.
// assumes sys_clk at the package rate.
`timescale 1ns/1ps
`default_nettype none
module dps_tick import dps_pkg::*; #(
  parameter int DIV = TICK_DIV
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  output logic tick
);
  logic [31:0] cnt_reg;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnt_reg <= 32'h0;
      tick <= 1'b0;
    end else if (clk_en) begin
      tick <= (cnt_reg == 32'(DIV - 1));
      if (cnt_reg == 32'(DIV - 1)) begin
        cnt_reg <= 32'h0;
      end else begin
        cnt_reg <= cnt_reg + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/dps_properties.sv
// dps_properties: port-level checks for the protection supervisor.
// assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module dps_properties (
  // clocking
  input wire logic sys_clk,
  input wire logic reset,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // drive side
  input wire logic vf_mode,
  input wire logic [15:0] freq_cmd,
  input wire logic [15:0] freq_out,
  input wire logic cur_limiting,
  input wire logic quick_limit,
  input wire logic fault_reset,
  input wire logic fault_reset_pulse,
  input wire logic fault_report,
  input wire logic coast_stop,
  input wire logic method_stop
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic rd_take;
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  rdata_hold_a: assert property (!$past(rd_take) |-> $stable(hrdata))
    else $error("read data moved without a read");
  limit_vf_only_a: assert property (!vf_mode && $past(!vf_mode) |-> !cur_limiting)
    else $error("limiting outside v/f mode");
  limit_cut_a: assert property (cur_limiting [*3] ##0 $stable(freq_cmd) |-> freq_out < freq_cmd)
    else $error("limiting without frequency cut");
  quick_vf_a: assert property ($past(!vf_mode) |-> !quick_limit)
    else $error("quick limit outside v/f mode");
  pulse_single_a: assert property (fault_reset_pulse |=> !fault_reset_pulse)
    else $error("retry reset pulse too long");
  pulse_unlatched_a: assert property (fault_reset_pulse |-> !fault_report)
    else $error("retry while fault reported");
  latch_hold_a: assert property (fault_report && !fault_reset |=> fault_report)
    else $error("reported fault dropped without reset");
  latch_stopped_a: assert property ($past(fault_report) && fault_report |-> coast_stop || method_stop)
    else $error("reported fault without stop");
  stop_excl_a: assert property (!(coast_stop && method_stop))
    else $error("coast and method stop together");
endmodule
bind dps_top dps_properties u_props (.sys_clk(sys_clk), .reset(reset), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .vf_mode(vf_mode), .freq_cmd(freq_cmd), .freq_out(freq_out),
  .cur_limiting(cur_limiting), .quick_limit(quick_limit), .fault_reset(fault_reset),
  .fault_reset_pulse(fault_reset_pulse), .fault_report(fault_report),
  .coast_stop(coast_stop), .method_stop(method_stop));
`default_nettype wire

// file: dv/dps_plant.sv
// dps_plant: behavioural power stage, current sense and fault detectors.
// assumes sensing lags the supervisor's commands by one clock.
`timescale 1ns/1ps
`default_nettype none
module dps_plant (
  // clocking
  input wire logic sys_clk,
  // supervisor commands
  input wire logic [15:0] freq_out,
  input wire logic coast_stop,
  input wire logic method_stop,
  // scenario controls
  input wire logic run_cmd,
  input wire logic heavy,
  input wire logic [11:0] fault_set,
  // sensed values
  output logic [10:0] out_current = 11'h000,
  output logic [11:0] fault_in = 12'h000,
  output logic running = 1'b0
);
  // heavy load current follows frequency, so a cut relieves it
  always_ff @(posedge sys_clk) begin
    running <= run_cmd && !coast_stop && !method_stop;
    fault_in <= fault_set;
    if (!running) out_current <= 11'h000;
    else if (heavy) out_current <= freq_out[10:0];
    else out_current <= 11'h032;
  end
endmodule
`default_nettype wire

// file: dv/tb.sv
// tb: self-checking bench for the protection supervisor.
// assumes dps_top with a short tick and the plant model on its drive side.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb import dps_pkg::*;;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, running;
  logic [15:0] in_voltage = 16'h0190, rated_voltage = 16'h0190, freq_cmd = 16'h0064;
  logic [15:0] vf_freq = 16'hffff, vf_voltage = 16'h0000, max_voltage = 16'h0000;
  logic vf_mode = 1'b1, decelerating = 1'b0, dc_braking = 1'b0, fault_reset = 1'b0;
  logic run_cmd = 1'b1, heavy = 1'b0;
  logic [11:0] fault_set = 12'h000;
  logic [11:0] fault_in;
  logic [10:0] out_current;
  logic [15:0] freq_out, volt_out;
  logic cur_limiting, quick_limit, fault_reset_pulse, fault_report, fault_do;
  logic coast_stop, method_stop, underload_do;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  dps_top #(.TICK_CYCLES(4), .NFAULT(12)) u_dut (
    .sys_clk(sys_clk), .reset(reset), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .out_current(out_current),
    .in_voltage(in_voltage), .rated_voltage(rated_voltage), .freq_cmd(freq_cmd),
    .vf_freq(vf_freq), .vf_voltage(vf_voltage), .max_voltage(max_voltage), .vf_mode(vf_mode),
    .running(running), .decelerating(decelerating), .dc_braking(dc_braking),
    .fault_reset(fault_reset), .fault_in(fault_in), .freq_out(freq_out), .volt_out(volt_out),
    .cur_limiting(cur_limiting), .quick_limit(quick_limit),
    .fault_reset_pulse(fault_reset_pulse), .fault_report(fault_report), .fault_do(fault_do),
    .coast_stop(coast_stop), .method_stop(method_stop), .underload_do(underload_do));
  dps_plant u_plant (.sys_clk(sys_clk), .freq_out(freq_out), .coast_stop(coast_stop),
    .method_stop(method_stop), .run_cmd(run_cmd), .heavy(heavy), .fault_set(fault_set),
    .out_current(out_current), .fault_in(fault_in), .running(running));
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // a hang ends the run rather than the simulator's own limit
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    `CHK(r & m, e)
  endtask
  task automatic pulse_reset();
    fault_reset <= 1'b1;
    @(posedge sys_clk);
    fault_reset <= 1'b0;
    repeat (40) @(posedge sys_clk);
  endtask
  task automatic t_regs();
    rd_chk(OFS_CURLIM, 32'h07ff0013, 32'h05dc0002);
    rd_chk(OFS_RETRY, 32'h0000011f, 32'h0);
    rd_chk(OFS_RETRY_IVL, 32'hfff, 32'h32);
    rd_chk(OFS_RETRY_RST, 32'hfff, 32'h3e8);
    rd_chk(OFS_UNDERLOAD, 32'h03ff0031, 32'h00140010);
    rd_chk(OFS_UL_TIME, 32'hfff, 32'h64);
    rd_chk(OFS_VREG, 32'h3, 32'h1);
    wr(8'h30, 32'hffffffff);
    rd_chk(8'h30, 32'hffffffff, 32'h0);
    wr(OFS_STOP_A, 32'ha5);
    rd_chk(OFS_STOP_A, 32'hff, 32'ha5);
    wr(OFS_STOP_B, 32'hff);
    rd_chk(OFS_STOP_B, 32'hff, 32'h0f);
    wr(OFS_RETRY, 32'h19);
    rd_chk(OFS_RETRY, 32'h1f, 32'h14);
    wr(OFS_CURLIM, 32'h00640002);
    rd_chk(OFS_CURLIM, 32'h07ff0000, 32'h00c80000);
  endtask
  task automatic t_curlim();
    freq_cmd <= 16'h044c;
    heavy <= 1'b1;
    wr(OFS_CURLIM, 32'h03e80001);
    for (int i = 0; i < 300 && cur_limiting !== 1'b1; i++) @(posedge sys_clk);
    repeat (50) @(posedge sys_clk);
    `CHK(freq_out < 16'h044c, 1'b1)
    heavy <= 1'b0;
    repeat (20) @(posedge sys_clk);
    `CHK(cur_limiting, 1'b0)
    for (int i = 0; i < 3000 && freq_out !== 16'h044c; i++) @(posedge sys_clk);
    `CHK(freq_out, 16'h044c)
    heavy <= 1'b1;
    wr(OFS_CURLIM, 32'h03e80010);
    repeat (50) @(posedge sys_clk);
    `CHK({freq_out, cur_limiting, quick_limit}, {16'h044c, 2'b01})
    vf_mode <= 1'b0;
    wr(OFS_CURLIM, 32'h03e80011);
    repeat (50) @(posedge sys_clk);
    `CHK({freq_out, cur_limiting, quick_limit}, {16'h044c, 2'b00})
    heavy <= 1'b0;
    vf_mode <= 1'b1;
    wr(OFS_CURLIM, 32'h03e80002);
  endtask
  task automatic run_fault(input int f, input int np, input logic dox, input logic ms);
    int n;
    logic dseen;
    n = 0;
    dseen = 1'b0;
    fault_set <= 12'h001 << f;
    for (int i = 0; i < 600 && fault_report !== 1'b1; i++) begin
      @(posedge sys_clk);
      n += int'(fault_reset_pulse === 1'b1);
      dseen |= (fault_do === 1'b1) && (fault_report !== 1'b1);
    end
    fault_set <= 12'h000;
    `CHK(n, np)
    `CHK(dseen, dox)
    repeat (20) @(posedge sys_clk);
    `CHK(fault_report, 1'b1)
    `CHK({coast_stop, method_stop}, {~ms, ms})
    pulse_reset();
    `CHK(fault_report, 1'b0)
  endtask
  task automatic t_retry();
    wr(OFS_RETRY_IVL, 32'h1);
    wr(OFS_RETRY_RST, 32'h2);
    wr(OFS_STOP_A, 32'h02);
    wr(OFS_STOP_B, 32'h01);
    wr(OFS_RETRY, 32'h00010102);
    run_fault(0, 2, 1'b1, 1'b0);
    wr(OFS_RETRY, 32'h00010002);
    run_fault(0, 2, 1'b0, 1'b0);
    run_fault(1, 0, 1'b0, 1'b1);
    run_fault(8, 0, 1'b0, 1'b1);
    wr(OFS_RETRY, 32'h00010100);
    run_fault(0, 0, 1'b0, 1'b0);
    wr(OFS_RETRY, 32'h00010005);
    wr(OFS_RETRY_RST, 32'h28);
    for (int k = 1; k < 3; k++) begin
      fault_set <= 12'h001;
      @(posedge sys_clk);
      fault_set <= 12'h000;
      repeat (30) @(posedge sys_clk);
      rd_chk(OFS_STATUS, 32'h1f300000, k << 24);
    end
    repeat (300) @(posedge sys_clk);
    rd_chk(OFS_STATUS, 32'h1f300000, 32'h0);
  endtask
  task automatic t_underload();
    logic [3:0] ul_exp [3] = '{4'b1100, 4'b1010, 4'b0001};
    wr(OFS_UL_TIME, 32'h1);
    dc_braking <= 1'b1;
    wr(OFS_UNDERLOAD, 32'h00c80001);
    repeat (60) @(posedge sys_clk);
    `CHK(fault_report, 1'b0)
    dc_braking <= 1'b0;
    for (int a = 0; a < 3; a++) begin
      wr(OFS_UNDERLOAD, 32'h00c80001 | (a << 4));
      for (int i = 0; i < 200 && fault_report !== 1'b1 && underload_do !== 1'b1; i++)
        @(posedge sys_clk);
      repeat (3) @(posedge sys_clk);
      `CHK({fault_report, coast_stop, method_stop, underload_do}, ul_exp[a])
      wr(OFS_UNDERLOAD, 32'h00c80000);
      pulse_reset();
    end
  endtask
  task automatic vreg_case(input logic [1:0] m, input logic [15:0] vin, input logic dec,
                           input logic [15:0] e);
    wr(OFS_VREG, {30'h0, m});
    in_voltage <= vin;
    decelerating <= dec;
    repeat (8) @(posedge sys_clk);
    `CHK(volt_out, e)
  endtask
  task automatic t_vreg();
    rated_voltage <= 16'h0190;
    vf_voltage <= 16'h03e8;
    max_voltage <= 16'h07d0;
    vf_freq <= 16'h01f4;
    vreg_case(2'h0, 16'h01f4, 1'b0, 16'h03e8);
    vreg_case(2'h1, 16'h01f4, 1'b0, 16'h0320);
    vreg_case(2'h1, 16'h012c, 1'b0, 16'h07d0);
    vreg_case(2'h2, 16'h01f4, 1'b0, 16'h0320);
    vreg_case(2'h2, 16'h01f4, 1'b1, 16'h03e8);
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs();
    $display("done: register map");
    t_curlim();
    $display("done: current limit");
    t_retry();
    $display("done: fault retry");
    t_underload();
    $display("done: load loss");
    t_vreg();
    $display("done: voltage regulation");
    give_verdict();
  end
endmodule
`default_nettype wire
